// >>> src/saif_pkg.sv
package saif_pkg;

    // Control register address and layout.
    localparam logic [15:0] CTRL_OFFSET   = 16'h081f;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam int          FMT_LSB       = 0;
    localparam int          IBP_BIT       = 3;
    localparam int          ILP_BIT       = 4;
    localparam logic [7:0]  CTRL_WR_MASK  = 8'h1f;

    // Format field codes.
    localparam logic [2:0]  FMT_I2S       = 3'h0;
    localparam logic [2:0]  FMT_LEFT_J    = 3'h1;
    localparam logic [2:0]  FMT_TDM       = 3'h2;
    localparam logic [2:0]  FMT_RIGHT_J24 = 3'h3;
    localparam logic [2:0]  FMT_RIGHT_J20 = 3'h4;

    // Word geometry, counted in bit-clock periods.
    localparam int          LINES         = 4;
    localparam int          WORD_BITS     = 24;
    localparam logic [4:0]  I2S_LAST_POS  = 5'h18;
    localparam logic [4:0]  LJ_LAST_POS   = 5'h17;
    localparam logic [4:0]  TDM_LAST_POS  = 5'h18;
    localparam int          SLOT_POS_BITS = 5;
    localparam int          FRAME_BITS    = 8;

    // Decoded control fields.
    typedef struct packed {
        logic       frame_pol;
        logic       bit_pol;
        logic [2:0] format;
    } saif_cfg_type;

    // One delivered capture: a word from every input line plus its slot.
    typedef struct packed {
        logic [2:0]                      slot;
        logic [LINES-1:0][WORD_BITS-1:0] data;
    } saif_sample_type;

    // Left and right justified framings put the first channel on a high frame clock.
    function automatic logic saif_is_justified(input logic [2:0] fmt);
        return (fmt == FMT_LEFT_J) || (fmt == FMT_RIGHT_J24) || (fmt == FMT_RIGHT_J20);
    endfunction

endpackage

// >>> src/saif_input_port.sv
module saif_input_port (
    input  wire logic                    ref_clk,
    input  wire logic                    arst_n,
    input  wire logic                    clk_en,
    input  wire logic                    reg_wr_en,
    input  wire logic [15:0]             reg_addr,
    input  wire logic [7:0]              reg_wr_data,
    output logic      [7:0]              reg_rd_data,
    input  wire logic                    bit_clk,
    input  wire logic                    frame_clk,
    input  wire logic [3:0]              serial_audio_inputs,
    output saif_pkg::saif_sample_type    sample,
    output logic                         sample_valid
);

    // Register domain state.
    logic [7:0]                  ctrl_reg;
    logic [7:0]                  ctrl_next;
    logic [7:0]                  rd_reg;
    logic [7:0]                  rd_next;
    logic                        tgl_q1_reg;
    logic                        tgl_q2_reg;
    logic                        tgl_q3_reg;
    saif_pkg::saif_sample_type   sample_reg;
    saif_pkg::saif_sample_type   sample_next;
    logic                        valid_reg;
    logic                        valid_next;

    // Link domain state.
    logic [4:0]                  neg_cap_reg;
    logic [4:0]                  cfg_q1_reg;
    saif_pkg::saif_cfg_type      cfg_reg;
    logic                        ce_q1_reg;
    logic                        ce_q2_reg;
    logic                        lr_prev_reg;
    logic                        lr_prev_next;
    logic [7:0]                  pos_reg;
    logic [7:0]                  pos_next;
    logic [3:0][23:0]            shift_reg;
    logic [3:0][23:0]            shift_next;
    logic                        right_reg;
    logic                        right_next;
    saif_pkg::saif_sample_type   word_reg;
    saif_pkg::saif_sample_type   word_next;
    logic                        tgl_reg;
    logic                        tgl_next;

    // Link domain helper terms.
    logic [4:0]                  smp;
    logic                        lr_s;
    logic                        tdm;
    logic                        left_level;
    logic                        lr_chg;
    logic                        start;
    logic [7:0]                  pos;
    logic                        emit;
    logic [3:0][23:0]            shifted;

    assign reg_rd_data  = rd_reg;
    assign sample       = sample_reg;
    assign sample_valid = valid_reg;

    // Register port: only the control address is mapped, other reads give zero.
    always_comb begin
        ctrl_next = ctrl_reg;
        rd_next   = rd_reg;
        if (clk_en) begin
            if (reg_wr_en && reg_addr == saif_pkg::CTRL_OFFSET) begin
                ctrl_next = reg_wr_data & saif_pkg::CTRL_WR_MASK;
            end
            rd_next = (reg_addr == saif_pkg::CTRL_OFFSET) ? ctrl_reg : 8'h00;
        end
    end

    // A toggle from the link side announces a new word; the word is stable by then.
    always_comb begin
        sample_next = sample_reg;
        valid_next  = 1'b0;
        if (!clk_en) begin
            valid_next = valid_reg;
        end else if (tgl_q2_reg != tgl_q3_reg) begin
            sample_next = word_reg;
            valid_next  = 1'b1;
        end
    end

    // Register domain flip-flops.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg   <= saif_pkg::CTRL_RESET;
            rd_reg     <= 8'h00;
            tgl_q1_reg <= 1'b0;
            tgl_q2_reg <= 1'b0;
            tgl_q3_reg <= 1'b0;
            sample_reg <= '0;
            valid_reg  <= 1'b0;
        end else begin
            ctrl_reg   <= ctrl_next;
            rd_reg     <= rd_next;
            tgl_q1_reg <= tgl_reg;
            tgl_q2_reg <= tgl_q1_reg;
            if (clk_en) begin
                tgl_q3_reg <= tgl_q2_reg;
            end
            sample_reg <= sample_next;
            valid_reg  <= valid_next;
        end
    end

    // Falling-edge capture of frame clock and data for bit polarity 1.
    always_ff @(negedge bit_clk or negedge arst_n) begin
        if (!arst_n) begin
            neg_cap_reg <= 5'h00;
        end else begin
            neg_cap_reg <= {frame_clk, serial_audio_inputs};
        end
    end

    // Control bits and the enable cross into the link domain through two flops.
    always_ff @(posedge bit_clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_q1_reg <= 5'h00;
            cfg_reg    <= '0;
            ce_q1_reg  <= 1'b0;
            ce_q2_reg  <= 1'b0;
        end else begin
            cfg_q1_reg <= ctrl_reg[4:0];
            cfg_reg    <= cfg_q1_reg;
            ce_q1_reg  <= clk_en;
            ce_q2_reg  <= ce_q1_reg;
        end
    end

    // Pick the sample taken on the edge opposite the data change edge.
    always_comb begin
        smp  = cfg_reg.bit_pol ? neg_cap_reg : {frame_clk, serial_audio_inputs};
        lr_s = smp[4];
    end

    // Framing decode: polarity bits act on top of whatever the format says.
    always_comb begin
        tdm        = (cfg_reg.format == saif_pkg::FMT_TDM);
        left_level = cfg_reg.frame_pol ^ saif_pkg::saif_is_justified(cfg_reg.format);
        lr_chg     = (lr_s != lr_prev_reg);
        start      = tdm ? (lr_chg && lr_s == cfg_reg.frame_pol) : lr_chg;
        pos        = start ? 8'h00 : 8'(pos_reg + 8'h01);
        for (int i = 0; i < saif_pkg::LINES; i++) begin
            shifted[i] = {shift_reg[i][22:0], smp[i]};
        end
        unique case (cfg_reg.format)
            saif_pkg::FMT_LEFT_J:    emit = !tdm && pos == {3'h0, saif_pkg::LJ_LAST_POS};
            saif_pkg::FMT_TDM:       emit = pos[4:0] == saif_pkg::TDM_LAST_POS;
            saif_pkg::FMT_RIGHT_J24: emit = lr_chg;
            saif_pkg::FMT_RIGHT_J20: emit = lr_chg;
            default:                 emit = pos == {3'h0, saif_pkg::I2S_LAST_POS};
        endcase
    end

    // Shift, count bit positions and build each finished word.
    always_comb begin
        lr_prev_next = lr_s;
        pos_next     = pos;
        shift_next   = shifted;
        right_next   = start ? (lr_s != left_level) : right_reg;
        word_next    = word_reg;
        tgl_next     = tgl_reg;
        if (!ce_q2_reg) begin
            lr_prev_next = lr_prev_reg;
            pos_next     = pos_reg;
            shift_next   = shift_reg;
            right_next   = right_reg;
        end else if (emit) begin
            tgl_next = !tgl_reg;
            if (tdm) begin
                word_next.data = shifted;
                word_next.slot = pos[7:5];
            end else if (cfg_reg.format == saif_pkg::FMT_RIGHT_J24) begin
                word_next.data = shift_reg;
                word_next.slot = {2'h0, right_reg};
            end else if (cfg_reg.format == saif_pkg::FMT_RIGHT_J20) begin
                for (int i = 0; i < saif_pkg::LINES; i++) begin
                    word_next.data[i] = {shift_reg[i][19:0], 4'h0};
                end
                word_next.slot = {2'h0, right_reg};
            end else begin
                word_next.data = shifted;
                word_next.slot = {2'h0, right_next};
            end
        end
    end

    // Link domain flip-flops.
    always_ff @(posedge bit_clk or negedge arst_n) begin
        if (!arst_n) begin
            lr_prev_reg <= 1'b0;
            pos_reg     <= 8'h00;
            shift_reg   <= '0;
            right_reg   <= 1'b0;
            word_reg    <= '0;
            tgl_reg     <= 1'b0;
        end else begin
            lr_prev_reg <= lr_prev_next;
            pos_reg     <= pos_next;
            shift_reg   <= shift_next;
            right_reg   <= right_next;
            word_reg    <= word_next;
            tgl_reg     <= tgl_next;
        end
    end

    // Only the low five control bits are writable; a write shows one cycle later.
    property p_ctrl_write;
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_wr_en && reg_addr == saif_pkg::CTRL_OFFSET
        |=> ctrl_reg == ($past(reg_wr_data) & saif_pkg::CTRL_WR_MASK);
    endproperty
    a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

    // Reads of the control address return it with the reserved bits at zero.
    property p_ctrl_read;
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && reg_addr == saif_pkg::CTRL_OFFSET && !reg_wr_en
        |=> reg_rd_data == ctrl_reg && reg_rd_data[7:5] == 3'h0;
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read wrong");

    // The channel at a stereo boundary follows frame clock level and polarity.
    property p_stereo_side;
        @(posedge bit_clk) disable iff (!arst_n)
        ce_q2_reg && !tdm && lr_chg
        |=> right_reg == ($past(lr_s) ^ $past(cfg_reg.frame_pol)
                          ^ saif_pkg::saif_is_justified($past(cfg_reg.format)));
    endproperty
    a_stereo_side: assert property (p_stereo_side) else $error("channel side wrong");

    // A TDM frame restarts on the polarity-selected frame clock edge.
    property p_tdm_start;
        @(posedge bit_clk) disable iff (!arst_n)
        ce_q2_reg && tdm && lr_chg && lr_s == cfg_reg.frame_pol |=> pos_reg == 8'h00;
    endproperty
    a_tdm_start: assert property (p_tdm_start) else $error("tdm frame start missed");

    // The trailing edge of a frame pulse does not restart the frame.
    property p_tdm_pulse;
        @(posedge bit_clk) disable iff (!arst_n)
        ce_q2_reg && tdm && lr_chg && lr_s != cfg_reg.frame_pol
        |=> pos_reg == 8'($past(pos_reg) + 8'h01);
    endproperty
    a_tdm_pulse: assert property (p_tdm_pulse) else $error("pulse end restarted frame");

    // The sample used comes from the edge opposite the data change edge.
    property p_edge_pick;
        @(posedge bit_clk) disable iff (!arst_n)
        cfg_reg.bit_pol |-> smp == neg_cap_reg;
    endproperty
    a_edge_pick: assert property (p_edge_pick) else $error("wrong sampling edge");

    // A TDM word finishes 24 bits after an MSB delayed by one bit clock.
    property p_tdm_word;
        @(posedge bit_clk) disable iff (!arst_n)
        ce_q2_reg && tdm && tgl_next != tgl_reg |-> pos[4:0] == 5'h18;
    endproperty
    a_tdm_word: assert property (p_tdm_word) else $error("tdm msb misplaced");

    // The TDM slot number is the slot's position in the frame.
    property p_tdm_slot;
        @(posedge bit_clk) disable iff (!arst_n)
        ce_q2_reg && tdm && emit |=> word_reg.slot == $past(pos[7:5]);
    endproperty
    a_tdm_slot: assert property (p_tdm_slot) else $error("tdm channel misplaced");

    // A toggle leaving the synchroniser raises valid on the next enabled cycle.
    property p_deliver;
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && $changed(tgl_q2_reg) |=> valid_reg;
    endproperty
    a_deliver: assert property (p_deliver) else $error("word not delivered");

    // The valid pulse lasts a single enabled cycle, so one word is never taken twice.
    property p_valid_once;
        @(posedge ref_clk) disable iff (!arst_n)
        clk_en && valid_reg |=> !valid_reg;
    endproperty
    a_valid_once: assert property (p_valid_once) else $error("valid held too long");

    // A low enable freezes the control register, the read data and the delivered word.
    property p_freeze;
        @(posedge ref_clk) disable iff (!arst_n)
        !clk_en |=> $stable(ctrl_reg) && $stable(sample_reg) && $stable(rd_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("state moved while disabled");

    // Codes that are neither TDM nor justified frame a word as I2S, MSB one bit late.
    property p_i2s_word;
        @(posedge bit_clk) disable iff (!arst_n)
        ce_q2_reg && !tdm && !saif_pkg::saif_is_justified(cfg_reg.format) && emit
        |-> pos == {3'h0, saif_pkg::I2S_LAST_POS};
    endproperty
    a_i2s_word: assert property (p_i2s_word) else $error("i2s word misframed");

endmodule // saif_input_port

// >>> bench/saif_src.sv
// Behavioural audio source: drives bit clock, frame clock and the four data lines.
module saif_src (
    output logic       bit_clk,
    output logic       frame_clk,
    output logic [3:0] sdata
);
    timeunit 1ns;
    timeprecision 1ns;

    // The bit clock stands still between frames.
    initial begin
        bit_clk = 1'b1;
        frame_clk = 1'b1;
        sdata = 4'h0;
    end

    // One bit: lines change on one bit clock edge and are sampled on the other.
    task automatic put(input logic bp, input logic fl, input logic [3:0] d);
        bit_clk = bp;
        frame_clk = fl;
        sdata = d;
        #40;
        bit_clk = ~bp;
        #40;
    endtask

    // One frame of two stereo slots or eight TDM slots of 32 bits, with lead-in and tail.
    task automatic frame(input logic [2:0] fmt, input logic fp, input logic bp,
                         input logic [23:0] w [4][8]);
        int         n;
        int         nb;
        int         off;
        logic       lv;
        logic       pls;
        logic [3:0] d;
        n = (fmt == 3'h2) ? 8 : 2;
        nb = (fmt == 3'h4) ? 20 : 24;
        off = (fmt == 3'h1) ? 0 : (fmt >= 3'h3) ? 32 - nb : 1;
        lv = fp ^ ((fmt == 3'h1) || (fmt >= 3'h3));
        pls = (fmt == 3'h2) && bp;
        repeat (4) put(bp, ~lv, 4'h0);
        for (int s = 0; s < n; s++) begin
            for (int b = 0; b < 32; b++) begin
                d = {4{b[0]}};
                for (int k = 0; k < 4; k++) begin
                    if (b >= off && b < off + nb && (n == 2 || k == 0)) begin
                        d[k] = w[k][s][23 - (b - off)];
                    end
                end
                if (pls) begin
                    put(bp, (s == 0 && b == 0) ? lv : ~lv, d);
                end else begin
                    put(bp, (s < n / 2) ? lv : ~lv, d);
                end
            end
        end
        repeat (2) put(bp, lv, 4'h0);
    endtask
endmodule // saif_src

// >>> bench/serial_audio_input_format_bench.sv
// Self-checking bench: register access, then every format under every polarity pair.
module serial_audio_input_format_bench;
    timeunit 1ns;
    timeprecision 1ns;

    logic                      ref_clk = 1'b0;
    logic                      arst_n = 1'b0;
    logic                      clk_en = 1'b1;
    logic                      reg_wr_en = 1'b0;
    logic [15:0]               reg_addr = 16'h0000;
    logic [7:0]                reg_wr_data = 8'h00;
    logic [7:0]                reg_rd_data;
    logic                      bit_clk;
    logic                      frame_clk;
    logic [3:0]                sdata;
    logic                      sample_valid;
    saif_pkg::saif_sample_type sample;
    saif_pkg::saif_sample_type q[$];
    logic [23:0]               w [4][8];
    logic [31:0]               seed = 32'ha3a7b4b1;
    int                        miscompares = 0;
    int                        tests_run = 0;

    saif_input_port saif_input_port_i (.ref_clk(ref_clk), .arst_n(arst_n), .clk_en(clk_en),
        .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .bit_clk(bit_clk), .frame_clk(frame_clk),
        .serial_audio_inputs(sdata), .sample(sample), .sample_valid(sample_valid));
    saif_src saif_src_i (.bit_clk(bit_clk), .frame_clk(frame_clk), .sdata(sdata));

    // The 25 MHz register clock.
    always #20 ref_clk = ~ref_clk;

    // Every delivered word is queued for later comparison.
    always @(posedge ref_clk) begin
        if (sample_valid === 1'b1) begin
            q.push_back(sample);
        end
    end

    function automatic logic [31:0] xs_next();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected word of slot s; twenty-bit words keep only their top twenty bits.
    function automatic saif_pkg::saif_sample_type expect_word(input logic [2:0] fmt, input int s);
        saif_pkg::saif_sample_type e;
        e.slot = 3'(s);
        for (int k = 0; k < 4; k++) begin
            e.data[k] = (fmt == saif_pkg::FMT_TDM && k > 0) ? 24'h0 :
                w[k][s] & ((fmt == saif_pkg::FMT_RIGHT_J20) ? 24'hfffff0 : 24'hffffff);
        end
        return e;
    endfunction

    task automatic check(input logic [98:0] g, input logic [98:0] e);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge ref_clk);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wr_data = d;
        @(negedge ref_clk);
        reg_wr_en = 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        @(negedge ref_clk);
        d = reg_rd_data;
    endtask

    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // A hang ends the run as a failure.
    initial begin
        #2000000;
        miscompares++;
        finish_test();
    end

    // Register checks first, then a frame for each format and polarity pair.
    initial begin : main
        logic [7:0]                d;
        logic [31:0]               r;
        logic [2:0]                fmt;
        logic [2:0]                code;
        int                        n;
        saif_pkg::saif_sample_type g;
        repeat (4) @(negedge ref_clk);
        arst_n = 1'b1;
        rd(saif_pkg::CTRL_OFFSET, d);
        check(99'(d), 99'h0);
        wr(saif_pkg::CTRL_OFFSET, 8'hff);
        rd(saif_pkg::CTRL_OFFSET, d);
        check(99'(d), 99'h1f);
        r = xs_next();
        wr(16'h0820, r[7:0]);
        rd(16'h0820, d);
        check(99'(d), 99'h0);
        clk_en = 1'b0;
        wr(saif_pkg::CTRL_OFFSET, 8'h00);
        clk_en = 1'b1;
        rd(saif_pkg::CTRL_OFFSET, d);
        check(99'(d), 99'h1f);
        // The sixth pass writes an unused format code, which must still frame as I2S.
        for (int f = 0; f < 6; f++) begin
            for (int p = 0; p < 4; p++) begin
                fmt = (f == 5) ? saif_pkg::FMT_I2S : 3'(f);
                code = (f == 5) ? 3'h7 : fmt;
                r = xs_next();
                wr(saif_pkg::CTRL_OFFSET, {r[7:5], p[1], p[0], code});
                rd(saif_pkg::CTRL_OFFSET, d);
                check(99'(d), 99'({3'h0, p[1], p[0], code}));
                for (int k = 0; k < 4; k++) begin
                    for (int s = 0; s < 8; s++) begin
                        r = xs_next();
                        w[k][s] = r[23:0];
                    end
                end
                saif_src_i.frame(fmt, p[1], p[0], w);
                repeat (20) @(negedge ref_clk);
                n = (f == 2) ? 8 : 2;
                if (q.size() < n) begin
                    check(99'(q.size()), 99'(n));
                end else begin
                    for (int s = 0; s < n; s++) begin
                        g = q[q.size() - n + s];
                        if (f == 2) begin
                            g.data[3:1] = '0;
                        end
                        check(g, expect_word(fmt, s));
                    end
                end
                q.delete();
            end
        end
        finish_test();
    end
endmodule // serial_audio_input_format_bench
